// ### src/pin_remap_cfg.svh
/*
  Constants of the pin remap block: register addresses, field positions,
  writable masks and reset values.
  Assumes inclusion by bare name from files that need these values.
*/
`ifndef PIN_REMAP_CFG_SVH
`define PIN_REMAP_CFG_SVH

// ==========================================================================
// Register byte addresses
`define IRQSEL_ADDR        32'h40010008
`define REMAP_ADDR         32'h4001000C

// ==========================================================================
// Reset values and writable bit masks (reserved bits stay zero)
`define IRQSEL_RESET       32'h00000000
`define REMAP_RESET        32'h00000000
`define IRQSEL_MASK        32'h0000FFFF
`define REMAP_MASK         32'h077FFFFF

// ==========================================================================
// Field positions inside the remap register
`define DBG_LSB            24
`define SER2_LSB           20
`define ADC_REG_BIT        19
`define ADC_INJ_BIT        18
`define XTAL_BIT           17
`define TIM2_LSB           14
`define TIM1_LSB           10
`define SER1_LSB           6
`define I2C_LSB            3
`define SPI_LSB            0

// ==========================================================================
// Highest defined codes of the remap fields; timer1 also defines codes 12 to 15
`define SER2_MAX           3'h6
`define TIM1_MAX           4'h9
`define SER1_MAX           4'h9
`define SPI_MAX            3'h7

`endif

// ### src/pin_remap_pkg.sv
/*
  Types shared by the pin remap block.
  Assumes nothing of its surroundings.
*/
package pin_remap_pkg;

  // Source port of an interrupt line
  typedef enum logic [1:0] {
    PORT_A = 2'h0,
    PORT_B = 2'h1,
    PORT_C = 2'h2,
    PORT_D = 2'h3
  } port_sel_t;

  // One port: eight pins
  typedef logic [7:0] port_pins_t;

endpackage

// ### src/irq_line_mux.sv
/*
  Selects, for each of eight interrupt lines, pin x of one of four ports.
  Assumes port pins are synchronous to clock; output is registered.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_line_mux (
  // Clock and control
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clock_en,
  // Selectors, two bits per line
  input  wire logic [15:0] irq_line_port_sel,
  // Port pins
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic [7:0]  port_d_pins,
  // Selected lines
  output logic      [7:0]  irq_lines
);

  logic [7:0] lines_d;

  // Pick pin x of the chosen port for line x
  always_comb begin
    for (int x = 0; x < 8; x++) begin
      unique case (pin_remap_pkg::port_sel_t'(irq_line_port_sel[2*x +: 2]))
        pin_remap_pkg::PORT_A: lines_d[x] = port_a_pins[x];
        pin_remap_pkg::PORT_B: lines_d[x] = port_b_pins[x];
        pin_remap_pkg::PORT_C: lines_d[x] = port_c_pins[x];
        pin_remap_pkg::PORT_D: lines_d[x] = port_d_pins[x];
      endcase
    end
  end

  // Register so the top output comes from a flip-flop
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_lines <= 8'h00;
    end else if (clock_en) begin
      irq_lines <= lines_d;
    end
  end

endmodule // irq_line_mux

`default_nettype wire

// ### src/pin_remap.sv
/*
  Pin remap control: interrupt line port selection and peripheral
  remap register, with decoded routing outputs.
  Assumes a single 200 MHz clock, word-only register port, synchronous
  pins, and that peripherals and GPIO consume the decoded selects.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_cfg.svh"

module pin_remap (
  // Clock and control
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clock_en,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Port pins feeding the interrupt lines
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic [7:0]  port_d_pins,
  output logic      [7:0]  irq_lines,
  // Decoded routing selects
  output logic             single_wire_debug_port,
  output logic             debug_cfg_invalid,
  output logic      [2:0]  serial2_pin_remap,
  output logic             serial2_reserved,
  output logic             adc_regular_trigger_remap,
  output logic             adc_injected_trigger_remap,
  output logic             crystal_pin_release,
  output logic      [2:0]  timer2_pin_remap,
  output logic      [3:0]  timer1_pin_remap,
  output logic             timer1_reserved,
  output logic             timer1_ch1_from_osc,
  output logic      [3:0]  serial1_pin_remap,
  output logic             serial1_reserved,
  output logic      [2:0]  i2c_pin_remap,
  output logic      [2:0]  spi_pin_remap,
  output logic             spi_reserved
);

  // ========================================================================
  // Registers
  logic [31:0] irqsel_q;
  logic [31:0] remap_q;
  logic [31:0] rdata_d;

  // Writes store only the defined bits; reserved bits stay zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irqsel_q <= `IRQSEL_RESET;
      remap_q  <= `REMAP_RESET;
    end else if (clock_en && reg_write) begin
      // Whole word taken at once; no byte lanes exist on this port
      if (reg_addr == `IRQSEL_ADDR) begin
        irqsel_q <= reg_wdata & `IRQSEL_MASK;
      end
      if (reg_addr == `REMAP_ADDR) begin
        remap_q <= reg_wdata & `REMAP_MASK;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr)
      `IRQSEL_ADDR: rdata_d = irqsel_q;
      `REMAP_ADDR:  rdata_d = remap_q;
      default:      rdata_d = 32'h00000000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (clock_en) begin
      reg_rdata <= reg_read ? rdata_d : 32'h00000000;
    end
  end

  // ========================================================================
  // Field extraction
  logic [2:0] dbg_f;
  logic [2:0] ser2_f;
  logic [2:0] tim2_f;
  logic [3:0] tim1_f;
  logic [3:0] ser1_f;
  logic [2:0] i2c_f;
  logic [2:0] spi_f;

  assign dbg_f  = remap_q[`DBG_LSB +: 3];
  assign ser2_f = remap_q[`SER2_LSB +: 3];
  assign tim2_f = remap_q[`TIM2_LSB +: 3];
  assign tim1_f = remap_q[`TIM1_LSB +: 4];
  assign ser1_f = remap_q[`SER1_LSB +: 4];
  assign i2c_f  = remap_q[`I2C_LSB +: 3];
  assign spi_f  = remap_q[`SPI_LSB +: 3];

  // Any 1xx code maps to one set; fold it so consumers see one code
  function automatic logic [2:0] fold_i2c(input logic [2:0] code);
    return code[2] ? 3'h4 : code;
  endfunction

  // ========================================================================
  // Decoded outputs, registered; reserved codes raise a flag and, for all fields but
  // debug, the field is still passed so a consumer may fall back to default
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      single_wire_debug_port     <= 1'b1;
      debug_cfg_invalid          <= 1'b0;
      serial2_pin_remap          <= 3'h0;
      serial2_reserved           <= 1'b0;
      adc_regular_trigger_remap  <= 1'b0;
      adc_injected_trigger_remap <= 1'b0;
      crystal_pin_release        <= 1'b0;
      timer2_pin_remap           <= 3'h0;
      timer1_pin_remap           <= 4'h0;
      timer1_reserved            <= 1'b0;
      timer1_ch1_from_osc        <= 1'b0;
      serial1_pin_remap          <= 4'h0;
      serial1_reserved           <= 1'b0;
      i2c_pin_remap              <= 3'h0;
      spi_pin_remap              <= 3'h0;
      spi_reserved               <= 1'b0;
    end else if (clock_en) begin
      // Invalid debug codes keep the port enabled, the safe choice
      single_wire_debug_port     <= (dbg_f != 3'h4);
      debug_cfg_invalid          <= dbg_f[2] && (dbg_f != 3'h4);
      serial2_pin_remap          <= ser2_f;
      serial2_reserved           <= (ser2_f > `SER2_MAX);
      adc_regular_trigger_remap  <= remap_q[`ADC_REG_BIT];
      adc_injected_trigger_remap <= remap_q[`ADC_INJ_BIT];
      crystal_pin_release        <= remap_q[`XTAL_BIT];
      timer2_pin_remap           <= tim2_f;
      timer1_pin_remap           <= tim1_f;
      timer1_reserved            <= (tim1_f > `TIM1_MAX) && (tim1_f[3:2] != 2'h3);
      timer1_ch1_from_osc        <= (tim1_f[3:2] == 2'h3);
      serial1_pin_remap          <= ser1_f;
      serial1_reserved           <= (ser1_f > `SER1_MAX);
      i2c_pin_remap              <= fold_i2c(i2c_f);
      spi_pin_remap              <= spi_f;
      spi_reserved               <= (spi_f > `SPI_MAX);
    end
  end

  // ========================================================================
  // Interrupt line source selection
  irq_line_mux u_irq_mux (
    .clock             (clock),
    .reset_n           (reset_n),
    .clock_en          (clock_en),
    .irq_line_port_sel (irqsel_q[15:0]),
    .port_a_pins       (port_a_pins),
    .port_b_pins       (port_b_pins),
    .port_c_pins       (port_c_pins),
    .port_d_pins       (port_d_pins),
    .irq_lines         (irq_lines)
  );

endmodule // pin_remap

`default_nettype wire

// ### dv/pin_remap_monitor.sv
/*
  Checker of the pin remap block: decode relations and register port timing.
  Assumes it is bound to pin_remap and that clock_en stays high around writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_cfg.svh"

module pin_remap_monitor (
  // Clock, reset and register port
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        clock_en,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // Decoded selects
  input wire logic        single_wire_debug_port,
  input wire logic        debug_cfg_invalid,
  input wire logic [2:0]  serial2_pin_remap,
  input wire logic        serial2_reserved,
  input wire logic        adc_regular_trigger_remap,
  input wire logic        adc_injected_trigger_remap,
  input wire logic        crystal_pin_release,
  input wire logic [2:0]  timer2_pin_remap,
  input wire logic [3:0]  timer1_pin_remap,
  input wire logic        timer1_reserved,
  input wire logic        timer1_ch1_from_osc,
  input wire logic [3:0]  serial1_pin_remap,
  input wire logic        serial1_reserved,
  input wire logic [2:0]  i2c_pin_remap,
  input wire logic        spi_reserved
);
  // ==========================================================================
  // Properties, all in the single clock domain
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_osc_select:
    assert property (timer1_ch1_from_osc == (timer1_pin_remap[3:2] == 2'h3)) else $error("osc");
  a_tim1_reserved:
    assert property (timer1_reserved == (timer1_pin_remap[3:1] == 3'h5)) else $error("tim1");
  a_ser1_reserved:
    assert property (serial1_reserved == (serial1_pin_remap > 4'h9)) else $error("ser1");
  a_ser2_reserved:
    assert property (serial2_reserved == (serial2_pin_remap == 3'h7)) else $error("ser2");
  a_spi_no_reserved:
    assert property (!spi_reserved) else $error("spi flag");
  a_i2c_fold:
    assert property (i2c_pin_remap[2] |-> i2c_pin_remap[1:0] == 2'h0) else $error("i2c");
  a_debug_invalid:
    assert property (debug_cfg_invalid |-> single_wire_debug_port) else $error("debug");
  // A write lands in the register next cycle and in the selects one later
  a_write_fields:
    assert property (clock_en && reg_write && reg_addr == `REMAP_ADDR |-> ##2
      {adc_regular_trigger_remap, adc_injected_trigger_remap, crystal_pin_release,
       timer2_pin_remap, timer1_pin_remap, serial1_pin_remap} == $past(reg_wdata[19:6], 2))
      else $error("remap fields");
  a_write_debug:
    assert property (clock_en && reg_write && reg_addr == `REMAP_ADDR |-> ##2
      single_wire_debug_port == ($past(reg_wdata[26:24], 2) != 3'h4)) else $error("debug en");
  a_rdata_idle:
    assert property ($past(clock_en) && !$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("rdata idle");
endmodule // pin_remap_monitor

bind pin_remap pin_remap_monitor i_pin_remap_monitor (
  .clock, .reset_n, .clock_en, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .single_wire_debug_port, .debug_cfg_invalid, .serial2_pin_remap, .serial2_reserved,
  .adc_regular_trigger_remap, .adc_injected_trigger_remap, .crystal_pin_release,
  .timer2_pin_remap, .timer1_pin_remap, .timer1_reserved, .timer1_ch1_from_osc,
  .serial1_pin_remap, .serial1_reserved, .i2c_pin_remap, .spi_reserved
);
`default_nettype wire

// ### dv/tb_top.sv
/*
  Self-checking bench of the pin remap block: registers, decode and irq mux.
  Assumes the design sources and the constants header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_cfg.svh"

module tb_top;
  // ==========================================================================
  // Signals
  logic        clock     = 1'b0;
  logic        reset_n   = 1'b0;
  logic        clock_en  = 1'b1;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [31:0] reg_addr  = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] pins      = 32'h0;
  logic [31:0] reg_rdata;
  logic [7:0]  irq_lines;
  wire  [29:0] dec;
  logic [31:0] v;
  logic [31:0] r;
  int          failures    = 0;
  int          check_count = 0;
  int          cycles      = 0;
  logic [31:0] corner [4] = '{32'hFFFFFFFF, 32'h04000000, 32'h00003000, 32'h07F02AA8};

  pin_remap i_pin_remap (
    .clock(clock), .reset_n(reset_n), .clock_en(clock_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_a_pins(pins[7:0]), .port_b_pins(pins[15:8]), .port_c_pins(pins[23:16]),
    .port_d_pins(pins[31:24]), .irq_lines(irq_lines),
    .single_wire_debug_port(dec[29]), .debug_cfg_invalid(dec[28]),
    .serial2_pin_remap(dec[27:25]), .serial2_reserved(dec[24]),
    .adc_regular_trigger_remap(dec[23]), .adc_injected_trigger_remap(dec[22]),
    .crystal_pin_release(dec[21]), .timer2_pin_remap(dec[20:18]),
    .timer1_pin_remap(dec[17:14]), .timer1_reserved(dec[13]), .timer1_ch1_from_osc(dec[12]),
    .serial1_pin_remap(dec[11:8]), .serial1_reserved(dec[7]), .i2c_pin_remap(dec[6:4]),
    .spi_pin_remap(dec[3:1]), .spi_reserved(dec[0])
  );

  // ==========================================================================
  // Clock and hang guard; a few hundred cycles are needed, so 5000 is ample
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================================
  // Expected values
  function automatic logic [29:0] exp_dec(input logic [31:0] x);
    return {x[26:24] != 3'h4, x[26:24] > 3'h4, x[22:20], x[22:20] == 3'h7, x[19:10],
            x[13:11] == 3'h5, x[13:12] == 2'h3, x[9:6], x[9:6] > 4'h9,
            x[5] ? 3'h4 : x[5:3], x[2:0], 1'b0};
  endfunction
  // Line x takes pin x of the port its two select bits name
  function automatic logic [7:0] exp_irq(input logic [15:0] s, input logic [31:0] p);
    for (int x = 0; x < 8; x++) exp_irq[x] = p[8 * s[2 * x +: 2] + x];
  endfunction

  // ==========================================================================
  // Bus tasks, word accesses only
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic check_defaults;
    chk(dec, exp_dec(32'h0));
    rd(`IRQSEL_ADDR, r);
    chk(r, `IRQSEL_RESET);
    rd(`REMAP_ADDR, r);
    chk(r, `REMAP_RESET);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence: corners first, then random words, then a mid-run reset
  initial begin
    void'($urandom(32'h49D1));
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    #1 check_defaults();
    for (int i = 0; i < 40; i++) begin
      v = (i < 4) ? corner[i] : $urandom;
      wr(`REMAP_ADDR, v);
      @(posedge clock);
      #1 chk(dec, exp_dec(v));
      rd(`REMAP_ADDR, r);
      chk(r, v & `REMAP_MASK);
      wr(`IRQSEL_ADDR, v);
      pins <= $urandom;
      @(posedge clock);
      #1 chk(irq_lines, exp_irq(v[15:0], pins));
      rd(`IRQSEL_ADDR, r);
      chk(r, v & `IRQSEL_MASK);
    end
    // Unmapped place: writes vanish, reads give zero, the remap register keeps its value
    wr(32'h40010010, 32'hFFFFFFFF);
    rd(32'h40010010, r);
    chk(r, 32'h0);
    rd(`REMAP_ADDR, r);
    chk(r, v & `REMAP_MASK);
    // Enable low: a write and new pin levels must leave every state frozen
    clock_en <= 1'b0;
    r = irq_lines;
    pins <= ~pins;
    wr(`REMAP_ADDR, ~v);
    clock_en <= 1'b1;
    #1 chk(irq_lines, r);
    @(posedge clock);
    #1 chk(dec, exp_dec(v));
    rd(`REMAP_ADDR, r);
    chk(r, v & `REMAP_MASK);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1 check_defaults();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
